//--- pcs_pkg.sv
// Package of register map, field layout and carriers for the PLL synthesizer configuration block
package pcs_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_OUTPUT_ENABLE_MASK    = 8'h09;
	localparam logic [7:0] ADDR_BANK1_SOURCE_DIVISOR  = 8'h0c;
	localparam logic [7:0] ADDR_OSC_DRIVE_CONTROL     = 8'h12;
	localparam logic [7:0] ADDR_LOAD_CAPACITOR_CODE   = 8'h13;
	localparam logic [7:0] ADDR_PUMP_FEEDBACK_UPPER   = 8'h40;
	localparam logic [7:0] ADDR_FEEDBACK_BASE_LOWER   = 8'h41;
	localparam logic [7:0] ADDR_ODD_BIT_PREDIVIDER    = 8'h42;
	localparam logic [7:0] ADDR_CROSSPOINT_SELECT_A   = 8'h44;
	localparam logic [7:0] ADDR_CROSSPOINT_SELECT_B   = 8'h45;
	localparam logic [7:0] ADDR_CROSSPOINT_SELECT_C   = 8'h46;
	localparam logic [7:0] ADDR_BANK2_SOURCE_DIVISOR  = 8'h47;

	// ----------------------------------------------------------------
	// Field positions and fixed bit values
	// ----------------------------------------------------------------
	localparam int         NUM_OUTPUTS       = 6;
	localparam int         GAIN_LSB          = 3;
	localparam int         PUMP_LSB          = 2;
	localparam int         BANK_SRC_BIT      = 7;
	localparam int         ODD_BIT           = 7;
	localparam logic [7:0] DRIVE_FIXED_BITS  = 8'h20;
	localparam logic [2:0] PUMP_FIXED_BITS   = 3'h6;
	localparam logic [5:0] XPT_C_FIXED_BITS  = 6'h3f;

	// ----------------------------------------------------------------
	// Reset values (blank part: all programmable bits zero)
	// ----------------------------------------------------------------
	localparam logic [7:0] RESET_REG_VALUE   = 8'h00;

	// ----------------------------------------------------------------
	// Counter offsets and bank fixed taps
	// ----------------------------------------------------------------
	localparam logic [7:0]  PREDIV_OFFSET    = 8'h02;
	localparam logic [11:0] FEEDBACK_OFFSET  = 12'h004;
	localparam int          BANK1_FIXED_DIV  = 3;
	localparam int          BANK2_FIXED_DIV  = 4;

	// ----------------------------------------------------------------
	// Crosspoint source codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_REFERENCE     = 3'h0;
	localparam logic [2:0] SRC_BANK1_VAR     = 3'h1;
	localparam logic [2:0] SRC_BANK1_HALF    = 3'h2;
	localparam logic [2:0] SRC_BANK1_FIXED   = 3'h3;
	localparam logic [2:0] SRC_BANK2_VAR     = 3'h4;
	localparam logic [2:0] SRC_BANK2_HALF    = 3'h5;
	localparam logic [2:0] SRC_BANK2_FIXED   = 3'h6;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} pcs_wr_type;

	typedef struct packed {
		logic var_clk;
		logic half_clk;
		logic fixed_clk;
	} pcs_bank_out_type;

endpackage : pcs_pkg

//--- pcs_divider_bank.sv
// Post-divider bank with variable, half and fixed taps sharing one alignment point
`timescale 1ns/10ps
module pcs_divider_bank #(
	parameter int FIXED_DIV = 3
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_tick,
	input  wire logic [6:0]                i_divisor,
	output pcs_pkg::pcs_bank_out_type      o_taps
);
	import pcs_pkg::*;

	localparam logic [1:0] FIX_LAST = 2'(FIXED_DIV - 1);
	localparam logic [1:0] FIX_HIGH = 2'(FIXED_DIV / 2);

	logic [6:0]       cnt_reg;
	logic [6:0]       cnt_next;
	logic             half_reg;
	logic             half_next;
	logic [1:0]       fix_reg;
	logic [1:0]       fix_next;
	pcs_bank_out_type taps_reg;
	pcs_bank_out_type taps_next;
	logic [6:0]       div_seen_reg;
	wire  logic       restart  = (i_divisor != div_seen_reg);
	wire  logic [6:0] var_last = i_divisor - 7'h01;
	wire  logic [6:0] var_high = 7'((8'(i_divisor) + 8'h01) >> 1);
	wire  logic       wrap     = (cnt_reg >= var_last);

	// Counters; fixed taps restart at the variable wrap so rising edges coincide
	assign cnt_next  = wrap ? 7'h00 : cnt_reg + 7'h01;
	assign half_next = wrap ? 1'b0 : ~half_reg;
	assign fix_next  = (wrap || fix_reg == FIX_LAST) ? 2'h0 : fix_reg + 2'h1;
	assign taps_next = '{var_clk: cnt_next < var_high, half_clk: ~half_next, fixed_clk: fix_next < FIX_HIGH};

	// Advance on each source edge; a new divisor parks all taps low and forces a wrap on the next edge,
	// so the first rise after reprogramming is already aligned
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg      <= 7'h00;
			half_reg     <= 1'b0;
			fix_reg      <= 2'h0;
			taps_reg     <= '0;
			div_seen_reg <= RESET_REG_VALUE[6:0];
		end else begin
			div_seen_reg <= i_divisor;
			if (restart) begin
				cnt_reg  <= '1;
				taps_reg <= '0;
			end else if (i_tick) begin
				cnt_reg  <= cnt_next;
				half_reg <= half_next;
				fix_reg  <= fix_next;
				taps_reg <= taps_next;
			end
		end
	end

	assign o_taps = taps_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_half_tap_aligned: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_divisor[1:0] == 2'h0 && i_divisor >= 7'h04 && $stable(i_divisor) && $rose(taps_reg.var_clk))
		|-> $rose(taps_reg.half_clk))
		else $error("half tap not aligned with variable tap");

	a_fixed_tap_aligned: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(((FIXED_DIV == 3) ? (i_divisor == 7'h06) : (i_divisor[2:0] == 3'h0 && i_divisor >= 7'h08))
		&& $stable(i_divisor) && $rose(taps_reg.var_clk)) |-> $rose(taps_reg.fixed_clk))
		else $error("fixed tap not aligned with variable tap");

endmodule : pcs_divider_bank

//--- pcs_synth_config.sv
// Top of the PLL synthesizer configuration registers and digital divider control
`timescale 1ns/10ps
module pcs_synth_config (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  pcs_pkg::pcs_wr_type         i_wr,
	input  wire logic [7:0]             i_rd_addr,
	output logic [7:0]                  o_rd_data,
	input  wire logic                   i_ref_pin,
	input  wire logic                   i_vco_pin,
	output logic [1:0]                  o_oscillator_gain_code,
	output logic [7:0]                  o_crystal_tuning_code,
	output logic [2:0]                  o_pump_code,
	output logic                        o_ref_compare_pulse,
	output logic                        o_feedback_compare_pulse,
	output logic [pcs_pkg::NUM_OUTPUTS-1:0] o_clk_out,
	output logic [pcs_pkg::NUM_OUTPUTS-1:0] o_clk_oe_n
);
	import pcs_pkg::*;

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [5:0]  output_enable_bits_reg;
	logic [7:0]  bank1_reg;
	logic [1:0]  gain_reg;
	logic [7:0]  tuning_reg;
	logic [4:0]  pump_upper_reg;
	logic [7:0]  base_lower_reg;
	logic [7:0]  odd_prediv_reg;
	logic [7:0]  xpt_a_reg;
	logic [7:0]  xpt_b_reg;
	logic [1:0]  xpt_c_reg;
	logic [7:0]  bank2_reg;
	logic [7:0]  rd_data_reg;
	logic [7:0]  rd_data_next;

	// Write strobes per address; reserved addresses are left unmapped
	wire logic wr_oe   = i_wr.en && i_wr.addr == ADDR_OUTPUT_ENABLE_MASK;
	wire logic wr_b1   = i_wr.en && i_wr.addr == ADDR_BANK1_SOURCE_DIVISOR;
	wire logic wr_drv  = i_wr.en && i_wr.addr == ADDR_OSC_DRIVE_CONTROL;
	wire logic wr_cap  = i_wr.en && i_wr.addr == ADDR_LOAD_CAPACITOR_CODE;
	wire logic wr_pump = i_wr.en && i_wr.addr == ADDR_PUMP_FEEDBACK_UPPER;
	wire logic wr_low  = i_wr.en && i_wr.addr == ADDR_FEEDBACK_BASE_LOWER;
	wire logic wr_odd  = i_wr.en && i_wr.addr == ADDR_ODD_BIT_PREDIVIDER;
	wire logic wr_xa   = i_wr.en && i_wr.addr == ADDR_CROSSPOINT_SELECT_A;
	wire logic wr_xb   = i_wr.en && i_wr.addr == ADDR_CROSSPOINT_SELECT_B;
	wire logic wr_xc   = i_wr.en && i_wr.addr == ADDR_CROSSPOINT_SELECT_C;
	wire logic wr_b2   = i_wr.en && i_wr.addr == ADDR_BANK2_SOURCE_DIVISOR;

	// Register writes; only programmable fields are stored
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			output_enable_bits_reg <= RESET_REG_VALUE[5:0];
			bank1_reg              <= RESET_REG_VALUE;
			gain_reg               <= RESET_REG_VALUE[1:0];
			tuning_reg             <= RESET_REG_VALUE;
			pump_upper_reg         <= RESET_REG_VALUE[4:0];
			base_lower_reg         <= RESET_REG_VALUE;
			odd_prediv_reg         <= RESET_REG_VALUE;
			xpt_a_reg              <= RESET_REG_VALUE;
			xpt_b_reg              <= RESET_REG_VALUE;
			xpt_c_reg              <= RESET_REG_VALUE[1:0];
			bank2_reg              <= RESET_REG_VALUE;
		end else begin
			if (wr_oe)   output_enable_bits_reg <= i_wr.data[5:0];
			if (wr_b1)   bank1_reg      <= i_wr.data;
			if (wr_drv)  gain_reg       <= i_wr.data[GAIN_LSB+1:GAIN_LSB];
			if (wr_cap)  tuning_reg     <= i_wr.data;
			if (wr_pump) pump_upper_reg <= i_wr.data[4:0];
			if (wr_low)  base_lower_reg <= i_wr.data;
			if (wr_odd)  odd_prediv_reg <= i_wr.data;
			if (wr_xa)   xpt_a_reg      <= i_wr.data;
			if (wr_xb)   xpt_b_reg      <= i_wr.data;
			if (wr_xc)   xpt_c_reg      <= i_wr.data[7:6];
			if (wr_b2)   bank2_reg      <= i_wr.data;
		end
	end

	// Readback with fixed bits restored; unmapped addresses read zero
	always_comb begin
		rd_data_next = 8'h00;
		if (i_rd_addr == ADDR_OUTPUT_ENABLE_MASK) begin
			rd_data_next = {2'h0, output_enable_bits_reg};
		end else if (i_rd_addr == ADDR_BANK1_SOURCE_DIVISOR) begin
			rd_data_next = bank1_reg;
		end else if (i_rd_addr == ADDR_OSC_DRIVE_CONTROL) begin
			rd_data_next = DRIVE_FIXED_BITS | {3'h0, gain_reg, 3'h0};
		end else if (i_rd_addr == ADDR_LOAD_CAPACITOR_CODE) begin
			rd_data_next = tuning_reg;
		end else if (i_rd_addr == ADDR_PUMP_FEEDBACK_UPPER) begin
			rd_data_next = {PUMP_FIXED_BITS, pump_upper_reg};
		end else if (i_rd_addr == ADDR_FEEDBACK_BASE_LOWER) begin
			rd_data_next = base_lower_reg;
		end else if (i_rd_addr == ADDR_ODD_BIT_PREDIVIDER) begin
			rd_data_next = odd_prediv_reg;
		end else if (i_rd_addr == ADDR_CROSSPOINT_SELECT_A) begin
			rd_data_next = xpt_a_reg;
		end else if (i_rd_addr == ADDR_CROSSPOINT_SELECT_B) begin
			rd_data_next = xpt_b_reg;
		end else if (i_rd_addr == ADDR_CROSSPOINT_SELECT_C) begin
			rd_data_next = {xpt_c_reg, XPT_C_FIXED_BITS};
		end else if (i_rd_addr == ADDR_BANK2_SOURCE_DIVISOR) begin
			rd_data_next = bank2_reg;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and edge ticks
	// ----------------------------------------------------------------
	logic [2:0] ref_sync_reg;
	logic [2:0] vco_sync_reg;
	wire  logic ref_level = ref_sync_reg[1];
	wire  logic ref_tick  = ref_sync_reg[1] & ~ref_sync_reg[2];
	wire  logic vco_tick  = vco_sync_reg[1] & ~vco_sync_reg[2];

	// Stage 0 feeds stage 1 only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_sync_reg <= 3'h0;
			vco_sync_reg <= 3'h0;
		end else begin
			ref_sync_reg <= {ref_sync_reg[1:0], i_ref_pin};
			vco_sync_reg <= {vco_sync_reg[1:0], i_vco_pin};
		end
	end

	// ----------------------------------------------------------------
	// Predivider and feedback counters
	// ----------------------------------------------------------------
	logic [7:0]  q_cnt_reg;
	logic [11:0] p_cnt_reg;
	logic        ref_pulse_reg;
	logic        fb_pulse_reg;
	wire  logic [7:0]  q_total = {1'b0, odd_prediv_reg[6:0]} + PREDIV_OFFSET;
	wire  logic [11:0] p_total = {1'b0, pump_upper_reg[1:0], base_lower_reg, 1'b0}
		+ {FEEDBACK_OFFSET[10:0], 1'b0} + {11'h000, odd_prediv_reg[ODD_BIT]};
	wire  logic        q_wrap  = (q_cnt_reg >= q_total - 8'h01);
	wire  logic        p_wrap  = (p_cnt_reg >= p_total - 12'h001);

	// Compare pulses once per divided period
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q_cnt_reg     <= 8'h00;
			p_cnt_reg     <= 12'h000;
			ref_pulse_reg <= 1'b0;
			fb_pulse_reg  <= 1'b0;
		end else begin
			ref_pulse_reg <= ref_tick && q_wrap;
			fb_pulse_reg  <= vco_tick && p_wrap;
			if (ref_tick) q_cnt_reg <= q_wrap ? 8'h00 : q_cnt_reg + 8'h01;
			if (vco_tick) p_cnt_reg <= p_wrap ? 12'h000 : p_cnt_reg + 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// Divider banks with source muxes
	// ----------------------------------------------------------------
	pcs_bank_out_type bank1_taps;
	pcs_bank_out_type bank2_taps;
	wire logic bank1_input_signal = bank1_reg[BANK_SRC_BIT] ? ref_tick : vco_tick;
	wire logic bank2_input_signal = bank2_reg[BANK_SRC_BIT] ? ref_tick : vco_tick;

	pcs_divider_bank #(.FIXED_DIV(BANK1_FIXED_DIV)) u_bank1 (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_tick    (bank1_input_signal),
		.i_divisor (bank1_reg[6:0]),
		.o_taps    (bank1_taps)
	);

	pcs_divider_bank #(.FIXED_DIV(BANK2_FIXED_DIV)) u_bank2 (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_tick    (bank2_input_signal),
		.i_divisor (bank2_reg[6:0]),
		.o_taps    (bank2_taps)
	);

	// ----------------------------------------------------------------
	// Crosspoint and output enables
	// ----------------------------------------------------------------
	function automatic logic pick_source(input logic [2:0] code, input logic ref_lvl,
		input pcs_bank_out_type b1, input pcs_bank_out_type b2);
		logic s;
		s = 1'b0;
		case (code)
			SRC_REFERENCE:   s = ref_lvl;
			SRC_BANK1_VAR:   s = b1.var_clk;
			SRC_BANK1_HALF:  s = b1.half_clk;
			SRC_BANK1_FIXED: s = b1.fixed_clk;
			SRC_BANK2_VAR:   s = b2.var_clk;
			SRC_BANK2_HALF:  s = b2.half_clk;
			SRC_BANK2_FIXED: s = b2.fixed_clk;
			default:         s = 1'b0;
		endcase
		return s;
	endfunction : pick_source

	wire logic [17:0] xpt_fields = {xpt_a_reg, xpt_b_reg, xpt_c_reg};
	logic [NUM_OUTPUTS-1:0] clk_out_reg;
	logic [NUM_OUTPUTS-1:0] clk_oe_n_reg;
	wire  logic [NUM_OUTPUTS-1:0] clk_out_next;

	// Each output takes its three-bit code, first output in the top bits
	genvar k;
	generate
		for (k = 0; k < NUM_OUTPUTS; k++) begin : g_out
			wire logic [2:0] output_source_select = xpt_fields[17-3*k -: 3];
			assign clk_out_next[k] = output_enable_bits_reg[k]
				& pick_source(output_source_select, ref_level, bank1_taps, bank2_taps);
		end
	endgenerate

	// Output flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_out_reg  <= '0;
			clk_oe_n_reg <= '1;
			rd_data_reg  <= 8'h00;
		end else begin
			clk_out_reg  <= clk_out_next;
			clk_oe_n_reg <= ~output_enable_bits_reg;
			rd_data_reg  <= rd_data_next;
		end
	end

	assign o_rd_data                = rd_data_reg;
	assign o_oscillator_gain_code   = gain_reg;
	assign o_crystal_tuning_code    = tuning_reg;
	assign o_pump_code              = pump_upper_reg[4:2];
	assign o_ref_compare_pulse      = ref_pulse_reg;
	assign o_feedback_compare_pulse = fb_pulse_reg;
	assign o_clk_out                = clk_out_reg;
	assign o_clk_oe_n               = clk_oe_n_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_pump_bits_fixed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_rd_addr == ADDR_PUMP_FEEDBACK_UPPER) |=> (o_rd_data[7:5] == PUMP_FIXED_BITS))
		else $error("pump register top bits not fixed");

	a_gain_field_taken: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_drv |=> (o_oscillator_gain_code == $past(i_wr.data[4:3])))
		else $error("gain code not taken from bits 4..3");

	a_tuning_code_taken: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_cap |=> (o_crystal_tuning_code == $past(i_wr.data)))
		else $error("load capacitor code not stored");

	a_prediv_total: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		q_total == {1'b0, odd_prediv_reg[6:0]} + 8'h02 && q_total >= 8'h02 && q_total <= 8'h81)
		else $error("predivider total out of range");

	a_feedback_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		p_total >= 12'h008 && p_total <= 12'h807 && p_total[0] == odd_prediv_reg[ODD_BIT])
		else $error("feedback total out of range");

	a_disabled_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(output_enable_bits_reg == 6'h00) |=> (o_clk_out == 6'h00 && o_clk_oe_n == 6'h3f))
		else $error("disabled output not held off");

	a_ref_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(xpt_a_reg[7:5] == SRC_REFERENCE && output_enable_bits_reg[0]) |=> (o_clk_out[0] == $past(ref_level)))
		else $error("reference code not routed");

	a_reserved_code_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(xpt_a_reg[7:5] == 3'h7) |=> (o_clk_out[0] == 1'b0))
		else $error("reserved source code not quiet");

endmodule : pcs_synth_config

//--- pcs_host_model.sv
// Host model: writes registers and drives the reference and VCO pins
`timescale 1ns/10ps
module pcs_host_model (
	input  wire logic           i_clk,
	output pcs_pkg::pcs_wr_type o_wr,
	output logic                o_ref_pin,
	output logic                o_vco_pin
);
	import pcs_pkg::*;

	// Reference pin, 160 ns period, kept off the clock edge
	initial begin
		o_ref_pin = 1'b0;
		#5;
		forever #80 o_ref_pin = ~o_ref_pin;
	end

	// VCO pin, 120 ns period, high time well above two clocks
	initial begin
		o_vco_pin = 1'b0;
		#7;
		forever #60 o_vco_pin = ~o_vco_pin;
	end

	initial o_wr = '0;

	// One byte write; released fields show inverted stale values
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1 o_wr = '{en: 1'b1, addr: a, data: d};
		@(posedge i_clk);
		#1 o_wr = '{en: 1'b0, addr: ~a, data: ~d};
	endtask : write
endmodule : pcs_host_model

//--- tb_pcs_synth_config.sv
// Self-checking testbench for the synthesizer configuration block
`timescale 1ns/10ps
module tb_pcs_synth_config;
	import pcs_pkg::*;
	logic       i_clk;
	logic       i_rst_n;
	pcs_wr_type wr;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic       ref_pin;
	logic       vco_pin;
	logic [1:0] gain;
	logic [7:0] tune;
	logic [2:0] pump;
	logic       ref_p;
	logic       fb_p;
	logic [5:0] clk_out;
	logic [5:0] oe_n;
	int         fail_count;
	int         check_count;
	int         cycles;
	int         i;
	localparam logic [7:0] RA [0:4] = '{8'h09, 8'h12, 8'h40, 8'h46, 8'h13};
	localparam logic [7:0] RE [0:4] = '{8'h00, 8'h20, 8'hc0, 8'h3f, 8'h00};

	pcs_host_model pcs_host_model_inst (.i_clk(i_clk), .o_wr(wr), .o_ref_pin(ref_pin), .o_vco_pin(vco_pin));

	pcs_synth_config pcs_synth_config_inst (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(wr), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
		.i_ref_pin(ref_pin), .i_vco_pin(vco_pin), .o_oscillator_gain_code(gain),
		.o_crystal_tuning_code(tune), .o_pump_code(pump), .o_ref_compare_pulse(ref_p),
		.o_feedback_compare_pulse(fb_p), .o_clk_out(clk_out), .o_clk_oe_n(oe_n)
	);

	// Clock and hang guard
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 10000) begin
			fail_count++;
			give_verdict();
		end
	end

	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr8(input logic [7:0] a, input logic [7:0] d);
		pcs_host_model_inst.write(a, d);
	endtask : wr8

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		#1 rd_addr = a;
		@(posedge i_clk);
		#1 chk(rd_data, exp);
	endtask : rd

	// Cycles between the second and third compare pulse
	task gap(input logic fb, input logic [7:0] exp);
		int n;
		int k;
		n = 0;
		k = 0;
		while (k < 3 && n < 400) begin
			@(posedge i_clk);
			#1;
			if ((fb ? fb_p : ref_p) === 1'b1) k++;
			if (k == 2) n++;
		end
		chk(n[7:0], exp);
	endtask : gap

	// Disabled outputs stay low; paired outputs rise together
	task watch(input logic [5:0] en, input logic pair);
		int r;
		logic [5:0] p;
		r = 0;
		@(posedge i_clk);
		#1 p = clk_out;
		repeat (300) begin
			@(posedge i_clk);
			#1;
			if ((clk_out & ~en) !== 6'h00) chk({2'h0, clk_out}, {2'h0, clk_out & en});
			if (clk_out[0] & ~p[0]) r++;
			if (pair && (clk_out[0] & ~p[0])) chk({7'h0, clk_out[1] & ~p[1]}, 8'h01);
			if (pair && (clk_out[2] & ~p[2])) chk({7'h0, clk_out[3] & ~p[3]}, 8'h01);
			p = clk_out;
		end
		chk({7'h0, r > 0}, 8'h01);
	endtask : watch

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict

	// Main sequence
	initial begin
		i_clk = 1'b0;
		i_rst_n = 1'b0;
		rd_addr = 8'h00;
		fail_count = 0;
		check_count = 0;
		cycles = 0;
		repeat (5) @(posedge i_clk);
		#1 i_rst_n = 1'b1;
		chk({2'h0, oe_n}, 8'h3f);
		for (i = 0; i < 5; i++) rd(RA[i], RE[i]);
		for (i = 0; i < 4; i++) begin
			wr8(ADDR_OSC_DRIVE_CONTROL, {3'h6, i[1:0], 3'h7});
			rd(ADDR_OSC_DRIVE_CONTROL, {3'h1, i[1:0], 3'h0});
			chk({6'h0, gain}, {6'h0, i[1:0]});
		end
		for (i = 0; i < 5; i++) begin
			wr8(ADDR_PUMP_FEEDBACK_UPPER, {3'h0, i[2:0], 2'h1});
			rd(ADDR_PUMP_FEEDBACK_UPPER, {3'h6, i[2:0], 2'h1});
			chk({5'h0, pump}, {5'h0, i[2:0]});
		end
		wr8(ADDR_PUMP_FEEDBACK_UPPER, 8'h00);
		wr8(ADDR_FEEDBACK_BASE_LOWER, 8'h04);
		wr8(ADDR_ODD_BIT_PREDIVIDER, 8'h83);
		wr8(ADDR_LOAD_CAPACITOR_CODE, 8'hab);
		rd(ADDR_LOAD_CAPACITOR_CODE, 8'hab);
		chk(tune, 8'hab);
		wr8(ADDR_LOAD_CAPACITOR_CODE, 8'h00);
		chk(tune, 8'h00);
		gap(1'b0, 8'h28);
		gap(1'b1, 8'h66);
		wr8(8'h43, 8'h55);
		rd(8'h43, 8'h00);
		wr8(ADDR_CROSSPOINT_SELECT_C, 8'h3f);
		rd(ADDR_CROSSPOINT_SELECT_C, 8'h3f);
		wr8(ADDR_OUTPUT_ENABLE_MASK, 8'hff);
		rd(ADDR_OUTPUT_ENABLE_MASK, 8'h3f);
		chk({2'h0, oe_n}, 8'h00);
		wr8(ADDR_OUTPUT_ENABLE_MASK, 8'h01);
		wr8(ADDR_CROSSPOINT_SELECT_A, 8'h00);
		wr8(ADDR_CROSSPOINT_SELECT_B, 8'h00);
		wr8(ADDR_CROSSPOINT_SELECT_C, 8'h3f);
		chk({2'h0, oe_n}, 8'h3e);
		watch(6'h01, 1'b0);
		wr8(ADDR_BANK1_SOURCE_DIVISOR, 8'h88);
		wr8(ADDR_BANK2_SOURCE_DIVISOR, 8'h08);
		rd(ADDR_BANK1_SOURCE_DIVISOR, 8'h88);
		wr8(ADDR_CROSSPOINT_SELECT_A, 8'h2a);
		wr8(ADDR_CROSSPOINT_SELECT_B, 8'h60);
		wr8(ADDR_OUTPUT_ENABLE_MASK, 8'h0f);
		watch(6'h0f, 1'b1);
		wr8(ADDR_BANK1_SOURCE_DIVISOR, 8'h86);
		wr8(ADDR_CROSSPOINT_SELECT_A, 8'h2e);
		watch(6'h0f, 1'b1);
		give_verdict();
	end
endmodule : tb_pcs_synth_config
